// >>> hw/drv_pwr_seq.v
`timescale 1ns/10ps
`default_nettype none

module drv_pwr_seq #(
	parameter LVL_W = 3
) (
	// Clock and reset
	input wire clk_sys,
	input wire reset,
	input wire clk_en,
	// Request and timing
	input wire power_req,
	input wire [31:0] delay_cyc,
	input wire [31:0] step_cyc,
	// Driver control
	output reg drv_on_q,
	output reg ramp_step_q,
	output reg [LVL_W-1:0] ramp_level_q
);

	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_DELAY = 2'h1;
	localparam [1:0] ST_RAMP = 2'h2;
	localparam [1:0] ST_ON = 2'h3;
	localparam [LVL_W-1:0] LVL_MAX = {LVL_W{1'b1}};

	reg [1:0] state_q;
	reg [31:0] cnt_q;

	// ****************************************
	// Power-on delay, then stepped ramp
	// ****************************************
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_q <= ST_IDLE;
			cnt_q <= 32'h0000_0000;
			drv_on_q <= 1'b0;
			ramp_step_q <= 1'b0;
			ramp_level_q <= {LVL_W{1'b0}};
		end else if (clk_en) begin
			ramp_step_q <= 1'b0;
			if (!power_req) begin
				// Power-down is immediate, no ramp down
				state_q <= ST_IDLE;
				drv_on_q <= 1'b0;
				ramp_level_q <= {LVL_W{1'b0}};
			end else begin
				case (state_q)
					ST_IDLE: begin
						state_q <= ST_DELAY;
						cnt_q <= delay_cyc;
					end
					ST_DELAY: begin
						if (cnt_q <= 32'h0000_0001) begin
							state_q <= ST_RAMP;
							cnt_q <= step_cyc;
						end else begin
							cnt_q <= cnt_q - 32'h0000_0001;
						end
					end
					ST_RAMP: begin
						if (step_cyc == 32'h0000_0000) begin
							// Zero step time jumps to full level
							ramp_level_q <= LVL_MAX;
							ramp_step_q <= 1'b1;
							drv_on_q <= 1'b1;
							state_q <= ST_ON;
						end else if (cnt_q <= 32'h0000_0001) begin
							ramp_level_q <= ramp_level_q + {{(LVL_W-1){1'b0}}, 1'b1};
							ramp_step_q <= 1'b1;
							cnt_q <= step_cyc;
							if (ramp_level_q == LVL_MAX - {{(LVL_W-1){1'b0}}, 1'b1}) begin
								drv_on_q <= 1'b1;
								state_q <= ST_ON;
							end
						end else begin
							cnt_q <= cnt_q - 32'h0000_0001;
						end
					end
					ST_ON: begin
						drv_on_q <= 1'b1;
					end
					default: begin
						state_q <= ST_IDLE;
					end
				endcase
			end
		end
	end

endmodule

`default_nettype wire

// >>> hw/drv_regs.v
// Function
// - Left switching field: 00 mix path, 01 line path, 10 direct high-power path.
// - Right switching field: 00 mix path, 01 line path, 10 direct high-power path.
// - Link field: 00/11 independent, 01 left follows right, 10 right follows left.
// - Power-on delay code maps to 0, 10us, 1ms, 50ms, 200ms, 400ms, 800ms, 2s, 4s.
// - Ramp step time field gives 0, 1, 2 or 4 ms.
// - Weak common-mode source: 0 supply divider, 1 bandgap reference.
// - Left mute bit mutes left channel when set; resets to 1.
// - Left volume: 7 bits, 0.5 dB attenuation per step, resets to zero.
// - Right mute bit mutes right channel when set; resets to 1.
// - Right volume: 7 bits, 0.5 dB attenuation per step, resets to zero.
`timescale 1ns/10ps
`default_nettype none
`include "drv_regs.vh"

module drv_regs #(
	parameter CYC_PER_US = `DRV_CLK_MHZ,
	parameter LVL_W = 3
) (
	// Clock and reset
	input wire clk_sys,
	input wire reset,
	input wire clk_en,
	// Register port
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire [7:0] reg_wdata,
	input wire reg_rd,
	output reg [7:0] reg_rdata_q,
	output reg reg_rvalid_q,
	// Output path routing
	output reg left_mix_path,
	output reg left_line_path,
	output reg left_direct_hp_path,
	output reg right_mix_path,
	output reg right_line_path,
	output reg right_direct_hp_path,
	// Effective digital volume
	output reg left_mute_q,
	output reg [6:0] left_atten_q,
	output reg right_mute_q,
	output reg [6:0] right_atten_q,
	// Output driver control
	output reg weak_cm_bandgap_q,
	input wire driver_power_req,
	output wire driver_on_q,
	output wire driver_ramp_step_q,
	output wire [LVL_W-1:0] driver_ramp_level_q
);

	reg [7:0] path_sel_q;
	reg [7:0] pop_red_q;
	reg [7:0] left_vol_q;
	reg [7:0] right_vol_q;
	reg [31:0] delay_cyc_d;
	reg [31:0] step_cyc_d;
	reg [7:0] rdata_d;
	reg [7:0] lvol_eff_d;
	reg [7:0] rvol_eff_d;

	// Time in microseconds to clock cycles
	function [31:0] us_to_cyc;
		input [31:0] t_us;
		begin
			us_to_cyc = t_us * CYC_PER_US;
		end
	endfunction

	// Switching code to one-hot {mix, line, direct}; 11 selects nothing
	function [2:0] path_decode;
		input [1:0] code;
		begin
			case (code)
				`DRV_SW_MIX: path_decode = 3'h4;
				`DRV_SW_LINE: path_decode = 3'h2;
				`DRV_SW_DIRECT: path_decode = 3'h1;
				default: path_decode = 3'h0;
			endcase
		end
	endfunction

	// ****************************************
	// Register writes
	// ****************************************
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			path_sel_q <= `DRV_RST_PATH_SEL;
			pop_red_q <= `DRV_RST_POP_RED;
			left_vol_q <= `DRV_RST_LEFT_VOL;
			right_vol_q <= `DRV_RST_RIGHT_VOL;
		end else if (clk_en && reg_wr) begin
			// Reserved bits are stored as written; software keeps them zero
			case (reg_addr)
				`DRV_OFS_PATH_SEL: path_sel_q <= reg_wdata;
				`DRV_OFS_POP_RED: pop_red_q <= reg_wdata;
				`DRV_OFS_LEFT_VOL: left_vol_q <= reg_wdata;
				`DRV_OFS_RIGHT_VOL: right_vol_q <= reg_wdata;
				default: path_sel_q <= path_sel_q;
			endcase
		end
	end

	// ****************************************
	// Read mux
	// ****************************************
	always @* begin
		case (reg_addr)
			`DRV_OFS_PATH_SEL: rdata_d = path_sel_q;
			`DRV_OFS_POP_RED: rdata_d = pop_red_q;
			`DRV_OFS_LEFT_VOL: rdata_d = left_vol_q;
			`DRV_OFS_RIGHT_VOL: rdata_d = right_vol_q;
			default: rdata_d = 8'h00;
		endcase
	end

	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			reg_rdata_q <= 8'h00;
			reg_rvalid_q <= 1'b0;
		end else if (clk_en) begin
			reg_rvalid_q <= reg_rd;
			if (reg_rd) begin
				reg_rdata_q <= rdata_d;
			end
		end
	end

	// ****************************************
	// Volume linking
	// ****************************************
	always @* begin
		lvol_eff_d = left_vol_q;
		rvol_eff_d = right_vol_q;
		case (path_sel_q[`DRV_LINK_HI:`DRV_LINK_LO])
			`DRV_LINK_L_FOLLOWS_R: lvol_eff_d = right_vol_q;
			`DRV_LINK_R_FOLLOWS_L: rvol_eff_d = left_vol_q;
			default: lvol_eff_d = left_vol_q;
		endcase
	end

	// ****************************************
	// Registered control outputs
	// ****************************************
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			{left_mix_path, left_line_path, left_direct_hp_path} <= 3'h4;
			{right_mix_path, right_line_path, right_direct_hp_path} <= 3'h4;
			left_mute_q <= 1'b1;
			left_atten_q <= 7'h00;
			right_mute_q <= 1'b1;
			right_atten_q <= 7'h00;
			weak_cm_bandgap_q <= 1'b0;
		end else if (clk_en) begin
			{left_mix_path, left_line_path, left_direct_hp_path} <=
				path_decode(path_sel_q[`DRV_LSW_HI:`DRV_LSW_LO]);
			{right_mix_path, right_line_path, right_direct_hp_path} <=
				path_decode(path_sel_q[`DRV_RSW_HI:`DRV_RSW_LO]);
			left_mute_q <= lvol_eff_d[`DRV_MUTE_BIT];
			left_atten_q <= lvol_eff_d[`DRV_VOL_HI:`DRV_VOL_LO];
			right_mute_q <= rvol_eff_d[`DRV_MUTE_BIT];
			right_atten_q <= rvol_eff_d[`DRV_VOL_HI:`DRV_VOL_LO];
			weak_cm_bandgap_q <= pop_red_q[`DRV_WCM_BIT];
		end
	end

	// ****************************************
	// Pop-reduction timing decode
	// ****************************************
	always @* begin
		case (pop_red_q[`DRV_PON_HI:`DRV_PON_LO])
			4'h0: delay_cyc_d = 32'h0000_0000;
			4'h1, 4'h2: delay_cyc_d = us_to_cyc(`DRV_T_10US);
			4'h3: delay_cyc_d = us_to_cyc(`DRV_T_1MS);
			4'h4, 4'h5: delay_cyc_d = us_to_cyc(`DRV_T_50MS);
			4'h6, 4'h7: delay_cyc_d = us_to_cyc(`DRV_T_200MS);
			4'h8: delay_cyc_d = us_to_cyc(`DRV_T_400MS);
			4'h9: delay_cyc_d = us_to_cyc(`DRV_T_800MS);
			4'hA: delay_cyc_d = us_to_cyc(`DRV_T_2S);
			4'hB: delay_cyc_d = us_to_cyc(`DRV_T_4S);
			// Reserved codes fall back to the longest delay, the safe side for pops
			default: delay_cyc_d = us_to_cyc(`DRV_T_4S);
		endcase
		case (pop_red_q[`DRV_STEP_HI:`DRV_STEP_LO])
			2'h0: step_cyc_d = 32'h0000_0000;
			2'h1: step_cyc_d = us_to_cyc(`DRV_T_1MS);
			2'h2: step_cyc_d = us_to_cyc(`DRV_T_2MS);
			default: step_cyc_d = us_to_cyc(`DRV_T_4MS);
		endcase
	end

	// ****************************************
	// Driver power-up sequencer
	// ****************************************
	drv_pwr_seq #(
		.LVL_W(LVL_W)
	) u_seq (
		.clk_sys(clk_sys),
		.reset(reset),
		.clk_en(clk_en),
		.power_req(driver_power_req),
		.delay_cyc(delay_cyc_d),
		.step_cyc(step_cyc_d),
		.drv_on_q(driver_on_q),
		.ramp_step_q(driver_ramp_step_q),
		.ramp_level_q(driver_ramp_level_q)
	);

endmodule

`default_nettype wire

// >>> hw/drv_regs.vh
`ifndef DRV_REGS_VH
`define DRV_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define DRV_OFS_PATH_SEL 8'h29
`define DRV_OFS_POP_RED 8'h2A
`define DRV_OFS_LEFT_VOL 8'h2B
`define DRV_OFS_RIGHT_VOL 8'h2C

// ****************************************
// Reset values
// ****************************************
`define DRV_RST_PATH_SEL 8'h00
`define DRV_RST_POP_RED 8'h00
`define DRV_RST_LEFT_VOL 8'h80
`define DRV_RST_RIGHT_VOL 8'h80

// ****************************************
// Field positions
// ****************************************
`define DRV_LSW_HI 7
`define DRV_LSW_LO 6
`define DRV_RSW_HI 5
`define DRV_RSW_LO 4
`define DRV_LINK_HI 1
`define DRV_LINK_LO 0
`define DRV_PON_HI 7
`define DRV_PON_LO 4
`define DRV_STEP_HI 3
`define DRV_STEP_LO 2
`define DRV_WCM_BIT 1
`define DRV_MUTE_BIT 7
`define DRV_VOL_HI 6
`define DRV_VOL_LO 0

// ****************************************
// Field codes
// ****************************************
`define DRV_SW_MIX 2'h0
`define DRV_SW_LINE 2'h1
`define DRV_SW_DIRECT 2'h2
`define DRV_LINK_L_FOLLOWS_R 2'h1
`define DRV_LINK_R_FOLLOWS_L 2'h2

// ****************************************
// Timing: clock in MHz, durations in microseconds
// ****************************************
`define DRV_CLK_MHZ 200
`define DRV_T_10US 10
`define DRV_T_1MS 1000
`define DRV_T_2MS 2000
`define DRV_T_4MS 4000
`define DRV_T_50MS 50000
`define DRV_T_200MS 200000
`define DRV_T_400MS 400000
`define DRV_T_800MS 800000
`define DRV_T_2S 2000000
`define DRV_T_4S 4000000

`endif

// >>> test/drv_regs_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module drv_regs_chk #(
	parameter LVL_W = 3
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clk_en,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	// Routing and volume
	input wire logic left_mix_path,
	input wire logic left_line_path,
	input wire logic left_direct_hp_path,
	input wire logic right_mix_path,
	input wire logic right_line_path,
	input wire logic right_direct_hp_path,
	input wire logic left_mute_q,
	input wire logic [6:0] left_atten_q,
	input wire logic right_mute_q,
	input wire logic [6:0] right_atten_q,
	// Driver control
	input wire logic weak_cm_bandgap_q,
	input wire logic driver_power_req,
	input wire logic driver_on_q,
	input wire logic driver_ramp_step_q,
	input wire logic [LVL_W-1:0] driver_ramp_level_q
);
	logic [1:0] link_q;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	// Own copy of the link field: when linked, a write to the leading channel's volume lands on the other channel too
	always @(posedge clk_sys or posedge reset) begin
		if (reset)
			link_q <= 2'h0;
		else if (clk_en && reg_wr && reg_addr == 8'h29)
			link_q <= reg_wdata[1:0];
	end
	function automatic logic [2:0] route_oh(input logic [1:0] c);
		return {c == 2'h0, c == 2'h1, c == 2'h2};
	endfunction
	// ****************
	// Properties
	// ****************
	// Isolated write, so only one register moves in the window
	sequence s_wr(logic [7:0] a);
		clk_en && reg_wr && reg_addr == a ##1 clk_en && !reg_wr;
	endsequence
	AST_LEFT_ROUTE: assert property (s_wr(8'h29) |=>
		{left_mix_path, left_line_path, left_direct_hp_path} == route_oh($past(reg_wdata[7:6], 2))) else $error("left route");
	AST_RIGHT_ROUTE: assert property (s_wr(8'h29) |=>
		{right_mix_path, right_line_path, right_direct_hp_path} == route_oh($past(reg_wdata[5:4], 2))) else $error("right route");
	AST_LVOL: assert property (link_q != 2'h1 ##0 s_wr(8'h2B) |=>
		{left_mute_q, left_atten_q} == $past(reg_wdata, 2)) else $error("left volume");
	AST_RVOL: assert property (link_q != 2'h2 ##0 s_wr(8'h2C) |=>
		{right_mute_q, right_atten_q} == $past(reg_wdata, 2)) else $error("right volume");
	AST_LINK_R: assert property (link_q == 2'h2 ##0 s_wr(8'h2B) |=>
		{right_mute_q, right_atten_q} == $past(reg_wdata, 2)) else $error("right not following left");
	AST_LINK_L: assert property (link_q == 2'h1 ##0 s_wr(8'h2C) |=>
		{left_mute_q, left_atten_q} == $past(reg_wdata, 2)) else $error("left not following right");
	AST_WCM: assert property (s_wr(8'h2A) |=>
		weak_cm_bandgap_q == $past(reg_wdata[1], 2)) else $error("common-mode source");
	AST_RST: assert property ($fell(reset) |->
		left_mute_q && right_mute_q && left_atten_q == 7'h00 && right_atten_q == 7'h00) else $error("reset volume");
	AST_ON_RISE: assert property ($rose(driver_on_q) |->
		driver_ramp_step_q && (&driver_ramp_level_q)) else $error("driver on before full ramp");
	AST_ON_DROP: assert property (!driver_power_req && clk_en |=>
		!driver_on_q && driver_ramp_level_q == '0) else $error("driver not released");
endmodule
bind drv_regs drv_regs_chk #(.LVL_W(LVL_W)) i_drv_regs_chk (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .left_mix_path(left_mix_path),
	.left_line_path(left_line_path), .left_direct_hp_path(left_direct_hp_path), .right_mix_path(right_mix_path),
	.right_line_path(right_line_path), .right_direct_hp_path(right_direct_hp_path), .left_mute_q(left_mute_q),
	.left_atten_q(left_atten_q), .right_mute_q(right_mute_q), .right_atten_q(right_atten_q),
	.weak_cm_bandgap_q(weak_cm_bandgap_q), .driver_power_req(driver_power_req), .driver_on_q(driver_on_q),
	.driver_ramp_step_q(driver_ramp_step_q), .driver_ramp_level_q(driver_ramp_level_q));
`default_nettype wire

// >>> test/drv_regs_test.sv
`timescale 1ns/10ps
`default_nettype none
module drv_regs_test;
	logic clk_sys = 0, reset = 1, clk_en = 1, reg_wr = 0, reg_rd = 0, driver_power_req = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_q, lv, rv;
	logic reg_rvalid_q, left_mix_path, left_line_path, left_direct_hp_path, right_mix_path, right_line_path;
	logic right_direct_hp_path, left_mute_q, right_mute_q, weak_cm_bandgap_q, driver_on_q, driver_ramp_step_q;
	logic [6:0] left_atten_q, right_atten_q;
	logic [2:0] driver_ramp_level_q;
	logic [7:0] exp_q[$];
	int fails = 0, total_checks = 0, pulses = 0, n, e, dp;
	int dus[4] = '{0, 10, 10, 1000};
	int sus[4] = '{0, 1000, 2000, 4000};
	int sc[4] = '{3, 2, 1, 0};
	always #2.5 clk_sys = ~clk_sys;
	// One cycle per microsecond keeps the millisecond waits short
	drv_regs #(.CYC_PER_US(1), .LVL_W(3)) i_drv_regs (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.reg_rvalid_q(reg_rvalid_q), .left_mix_path(left_mix_path), .left_line_path(left_line_path),
		.left_direct_hp_path(left_direct_hp_path), .right_mix_path(right_mix_path), .right_line_path(right_line_path),
		.right_direct_hp_path(right_direct_hp_path), .left_mute_q(left_mute_q), .left_atten_q(left_atten_q),
		.right_mute_q(right_mute_q), .right_atten_q(right_atten_q), .weak_cm_bandgap_q(weak_cm_bandgap_q),
		.driver_power_req(driver_power_req), .driver_on_q(driver_on_q), .driver_ramp_step_q(driver_ramp_step_q),
		.driver_ramp_level_q(driver_ramp_level_q));
	// ****************
	// Helpers
	// ****************
	function automatic logic [2:0] oh(input int c);
		return {c == 0, c == 1, c == 2};
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		total_checks++;
		if (seen !== want) begin
			fails++;
			$display("BAD %0t: seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_wr = w;
		reg_rd = r;
		reg_addr = a;
		reg_wdata = d;
	endtask
	task automatic idle(input int k);
		repeat (k) op(0, 0, 8'h00, 8'h00);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] want);
		exp_q.push_back(want);
		op(0, 1, a, 8'h00);
		idle(1);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(negedge clk_sys) begin
		pulses += (driver_ramp_step_q === 1'b1);
		if (reg_rvalid_q === 1'b1)
			check(reg_rdata_q, exp_q.size() > 0 ? exp_q.pop_front() : 16'hFFFF);
	end
	initial begin
		#350000;
		fails++;
		$display("BAD %0t: watchdog expired", $time);
		tally_and_finish();
	end
	// ****************
	// Scenarios
	// ****************
	initial begin
		void'($urandom(32'h93d7));
		repeat (5) @(negedge clk_sys);
		reset = 0;
		rd(8'h29, 8'h00);
		rd(8'h2A, 8'h00);
		rd(8'h2B, 8'h80);
		rd(8'h2C, 8'h80);
		rd(8'h2D, 8'h00);
		for (int c = 0; c < 3; c++) begin
			op(1, 0, 8'h29, {2'(c), 2'(2 - c), 4'h0});
			idle(2);
			check({left_mix_path, left_line_path, left_direct_hp_path, right_mix_path, right_line_path,
				right_direct_hp_path}, {oh(c), oh(2 - c)});
		end
		for (int k = 0; k < 4; k++) begin
			lv = 8'($urandom);
			rv = 8'($urandom);
			op(1, 0, 8'h29, {6'h00, 2'(k)});
			op(1, 0, 8'h2B, lv);
			idle(1);
			op(1, 0, 8'h2C, rv);
			idle(2);
			check({left_mute_q, left_atten_q, right_mute_q, right_atten_q}, {k == 1 ? rv : lv, k == 2 ? lv : rv});
			rd(8'h2B, lv);
			rd(8'h2C, rv);
		end
		// Strobe while disabled must leave the register alone
		op(1, 0, 8'h2B, 8'h00);
		clk_en = 0;
		op(0, 0, 8'h00, 8'h00);
		clk_en = 1;
		rd(8'h2B, lv);
		op(1, 0, 8'h2B, 8'h7F);
		idle(2);
		check({left_mute_q, left_atten_q}, 8'h7F);
		for (int j = 0; j < 4; j++) begin
			lv = {4'(j), 2'(sc[j]), 1'($urandom), 1'b0};
			op(1, 0, 8'h2A, lv);
			idle(2);
			check(weak_cm_bandgap_q, lv[1]);
			rd(8'h2A, lv);
			dp = dus[j] > 0 ? dus[j] : 1;
			// Request taken at the first edge, delay leaves after dp edges, on with the last step
			e = sus[sc[j]] > 0 ? 1 + dp + 7 * sus[sc[j]] : 2 + dp;
			pulses = 0;
			n = 0;
			driver_power_req = 1;
			while (driver_on_q !== 1'b1 && n < 40000) begin
				@(negedge clk_sys);
				n++;
			end
			check(n, e);
			check(driver_ramp_level_q, 3'h7);
			driver_power_req = 0;
			idle(1);
			check(pulses, sus[sc[j]] > 0 ? 7 : 1);
			check({driver_on_q, driver_ramp_level_q}, 4'h0);
		end
		// Long delay code must still be counting well past a millisecond
		op(1, 0, 8'h2A, 8'h40);
		idle(1);
		rd(8'h2A, 8'h40);
		driver_power_req = 1;
		repeat (1100) @(negedge clk_sys);
		check(driver_on_q, 1'b0);
		driver_power_req = 0;
		idle(1);
		reset = 1;
		idle(1);
		reset = 0;
		rd(8'h2B, 8'h80);
		idle(1);
		// Every queued read must have been answered
		check(exp_q.size(), 0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
